// ===== logic/wdt_pkg.sv
package wdt_pkg;

  // Core clock and low-speed oscillator rates
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned OSC_HZ = 32000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned DIV_W = 12;

  // Software reset delay, a least time, so it rounds up
  localparam int unsigned SRESET_NS = 16000;
  localparam int unsigned SRESET_CYCLES = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width covers the longest period of 2^18 ticks
  localparam int unsigned CNT_W = 18;

  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;

  // Guard field patterns and reset values
  localparam logic [4:0] GUARD_ENABLE = 5'h0a;
  localparam logic [4:0] GUARD_DISABLE = 5'h15;
  localparam logic [7:0] CTRL_RESET = 8'h53;

  // Interrupt status bit positions
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_GUARD = 1;
  localparam int unsigned IRQ_W = 2;

  typedef struct packed {
    logic [4:0] watchdog_guard_field;
    logic [2:0] timeout_period_select;
  } ctrl_t;

  typedef struct packed {
    logic reset_ctrl_soft_reset_flag;
    logic undervoltage_reset_flag;
    logic undervoltage_cfg_reset_flag;
    logic watchdog_ctrl_reset_flag;
  } cause_t;

  typedef enum logic [1:0] {
    GUARD_RUN,
    GUARD_STOP,
    GUARD_BAD
  } guard_mode_t;

endpackage

// ===== logic/wdt_core.sv
`timescale 1ns/1ps
// Functional notes
// RL1 - Counter advances on a ~32kHz oscillator tick derived from the core clock.
// RL2 - Period select 0..7 gives 2^8,10,12,14,15,16,17,18 ticks.
// RL3 - Guard 01010 runs the watchdog, 10101 stops it.
// RL4 - Any other guard value issues a full reset after the soft-reset delay.
// RL5 - A guard-value reset sets the watchdog control reset cause flag.
// RL6 - Control register powers up as 0x53, watchdog running.
// RL7 - Watchdog cause flag clears only by a software write of zero.
// RL8 - Overflow in run mode resets the device and sets the timeout flag.
// RL9 - Overflow in sleep or idle sets timeout and resets only PC and SP.
// RL10 - Counter clears on guard reset, clear instruction and halt instruction.
// RL11 - Cause register bits 7..4 read zero; cause flags power up zero.
// RL12 - Halt clears the counter; it keeps counting only when enabled.
// RL13 - Power-down flag clears on power-up or clear instruction, sets on halt.
// RL14 - Overflow at the selected count; counting restarts from zero after a clear.
module wdt_core #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned SRESET_CYC = wdt_pkg::SRESET_CYCLES,
  parameter int unsigned OSC_DIV_CYC = wdt_pkg::OSC_DIV
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_watchdog_instruction,
  input wire logic halt_instruction,
  input wire logic sleep_idle,
  input wire logic soft_reset_event,
  input wire logic undervoltage_event,
  input wire logic undervoltage_cfg_event,
  output logic device_reset,
  output logic pc_sp_reset,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic irq
);

  generate
    if (ADDR_W < 5 || SRESET_CYC < 1 || OSC_DIV_CYC < 2
        || OSC_DIV_CYC > (1 << wdt_pkg::DIV_W))
    begin : g_bad_param
      $error("wdt_core: unsupported parameter value");
    end
  endgenerate

  // Terminal count for a period select: 2^n - 1
  function automatic logic [wdt_pkg::CNT_W-1:0] period_last(input logic [2:0] sel);
    logic [4:0] expo;
    expo = (sel < 3'h4) ? {1'b0, sel, 1'b0} + 5'h08 : {2'b00, sel} + 5'h0b;
    period_last = (wdt_pkg::CNT_W'(1) << expo) - wdt_pkg::CNT_W'(1);
  endfunction

  wdt_pkg::ctrl_t ctrl_q, ctrl_d;
  wdt_pkg::cause_t cause_q, cause_d;
  logic [wdt_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [wdt_pkg::DIV_W-1:0] div_q;
  logic [31:0] srst_q;
  logic [wdt_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q;
  logic timeout_q, pdf_q, dev_rst_q, pcsp_q, irq_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // Bus decode
  wire [7:0] addr8 = 8'(paddr);
  wire hit_ctrl = addr8 == wdt_pkg::ADDR_CTRL;
  wire hit_cause = addr8 == wdt_pkg::ADDR_CAUSE;
  wire hit_status = addr8 == wdt_pkg::ADDR_STATUS;
  wire hit_ist = addr8 == wdt_pkg::ADDR_IRQ_STAT;
  wire hit_imask = addr8 == wdt_pkg::ADDR_IRQ_MASK;
  wire hit_count = addr8 == wdt_pkg::ADDR_COUNT;
  wire hit_any = hit_ctrl | hit_cause | hit_status | hit_ist | hit_imask | hit_count;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite & hit_any;

  // Guard decode
  wire wdt_pkg::guard_mode_t gmode =
    (ctrl_q.watchdog_guard_field == wdt_pkg::GUARD_ENABLE) ? wdt_pkg::GUARD_RUN :
    (ctrl_q.watchdog_guard_field == wdt_pkg::GUARD_DISABLE) ? wdt_pkg::GUARD_STOP :
    wdt_pkg::GUARD_BAD;
  wire run = gmode == wdt_pkg::GUARD_RUN; // [RL3]
  wire guard_bad = gmode == wdt_pkg::GUARD_BAD;
  // Delay restarts whenever the guard field turns legal again
  wire guard_fire = guard_bad & (srst_q == SRESET_CYC - 1); // [RL4]

  // Oscillator tick from the core clock
  wire tick = div_q == wdt_pkg::DIV_W'(OSC_DIV_CYC - 1); // [RL1]
  // Equality compare: a shorter select written after the counter has passed its terminal count waits for the counter to wrap
  wire ovf = run & tick & (cnt_q == period_last(ctrl_q.timeout_period_select)); // [RL2] [RL14]
  wire cnt_clear = guard_bad | clear_watchdog_instruction | halt_instruction; // [RL10] [RL12]
  wire full_rst = guard_fire | (ovf & ~sleep_idle);

  // Counter
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_clear || ovf || full_rst)
    begin
      cnt_d = '0; // [RL10] [RL14]
    end
    else if (run && tick)
    begin
      cnt_d = cnt_q + wdt_pkg::CNT_W'(1); // [RL1]
    end
  end

  // Control register; any full reset returns it to its power-on value
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (full_rst)
    begin
      ctrl_d = wdt_pkg::CTRL_RESET; // [RL6]
    end
    else if (wr_en && hit_ctrl)
    begin
      ctrl_d = pwdata[7:0];
    end
  end

  // Cause flags: hardware set wins over a software write
  always_comb
  begin
    cause_d = cause_q;
    if (wr_en && hit_cause)
    begin
      cause_d = pwdata[3:0]; // [RL7]
    end
    cause_d.watchdog_ctrl_reset_flag = cause_d.watchdog_ctrl_reset_flag | guard_fire; // [RL5]
    cause_d.reset_ctrl_soft_reset_flag = cause_d.reset_ctrl_soft_reset_flag | soft_reset_event;
    cause_d.undervoltage_reset_flag = cause_d.undervoltage_reset_flag | undervoltage_event;
    cause_d.undervoltage_cfg_reset_flag =
      cause_d.undervoltage_cfg_reset_flag | undervoltage_cfg_event;
  end

  // Interrupt status, write one to clear, set wins
  always_comb
  begin
    ist_d = ist_q;
    if (wr_en && hit_ist)
    begin
      ist_d = ist_q & ~pwdata[wdt_pkg::IRQ_W-1:0];
    end
    ist_d[wdt_pkg::IRQ_OVF] = ist_d[wdt_pkg::IRQ_OVF] | ovf;
    ist_d[wdt_pkg::IRQ_GUARD] = ist_d[wdt_pkg::IRQ_GUARD] | guard_fire;
  end

  // Read mux, loaded in the setup cycle so the data is ready with pready
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_q} :
    hit_cause ? {28'h0000000, cause_q} : // [RL11]
    hit_status ? {30'h00000000, pdf_q, timeout_q} :
    hit_ist ? {30'h00000000, ist_q} :
    hit_imask ? {30'h00000000, imask_q} :
    hit_count ? {14'h0000, cnt_q} : 32'h00000000;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_q <= '0;
      cnt_q <= '0;
      srst_q <= '0;
      ctrl_q <= wdt_pkg::CTRL_RESET; // [RL6]
      cause_q <= '0; // [RL11]
    end
    else
    begin
      div_q <= tick ? '0 : div_q + wdt_pkg::DIV_W'(1);
      cnt_q <= cnt_d;
      srst_q <= (guard_bad && !guard_fire) ? srst_q + 32'h00000001 : '0; // [RL4]
      ctrl_q <= ctrl_d;
      cause_q <= cause_d;
    end
  end

  // Status flags and reset pulses
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      timeout_q <= 1'b0;
      pdf_q <= 1'b0; // [RL13]
      dev_rst_q <= 1'b0;
      pcsp_q <= 1'b0;
    end
    else
    begin
      timeout_q <= ovf | (timeout_q & ~halt_instruction); // [RL8] [RL9]
      pdf_q <= halt_instruction | (pdf_q & ~clear_watchdog_instruction); // [RL13]
      dev_rst_q <= full_rst; // [RL8]
      pcsp_q <= ovf & sleep_idle; // [RL9]
    end
  end

  // Interrupts and bus answer
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      imask_q <= (wr_en && hit_imask) ? pwdata[wdt_pkg::IRQ_W-1:0] : imask_q;
      // A mask bit of one lets its status bit through to irq
      irq_q <= |(ist_q & imask_q);
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= setup ? rd_mux : prdata_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign device_reset = dev_rst_q;
  assign pc_sp_reset = pcsp_q;
  assign timeout_flag = timeout_q;
  assign power_down_flag = pdf_q;
  assign irq = irq_q;

  // Assertions below watch only what this core drives
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_por_ctrl_value: assert property ($fell(sys_rst) |-> ctrl_q == wdt_pkg::CTRL_RESET) // [RL6]
    else $error("control not 0x53 after reset");
  a_guard_run_counts: assert property ( // [RL3]
    run && tick && !cnt_clear && !ovf |=> cnt_q == $past(cnt_q) + 18'h00001)
    else $error("enabled watchdog did not count");
  a_guard_stop_holds: assert property ( // [RL3]
    gmode == wdt_pkg::GUARD_STOP && !cnt_clear |=> $stable(cnt_q))
    else $error("disabled watchdog counted");
  a_guard_fire_delay: assert property ( // [RL4]
    guard_fire |-> $past(guard_bad, 1) && !device_reset ##1 device_reset)
    else $error("guard reset not issued after delay");
  a_guard_sets_flag: assert property ( // [RL5]
    guard_fire |=> cause_q.watchdog_ctrl_reset_flag && ist_q[1])
    else $error("guard reset left cause flag clear");
  a_wdt_flag_sticky: assert property ( // [RL7]
    cause_q.watchdog_ctrl_reset_flag && !(wr_en && hit_cause)
    |=> cause_q.watchdog_ctrl_reset_flag)
    else $error("cause flag cleared by hardware");
  a_run_ovf_reset: assert property ( // [RL8]
    ovf && !sleep_idle |=> device_reset && timeout_flag && !pc_sp_reset)
    else $error("run overflow did not reset device");
  a_sleep_ovf_pcsp: assert property ( // [RL9]
    ovf && sleep_idle |=> pc_sp_reset && timeout_flag && !device_reset)
    else $error("sleep overflow wrong reset");
  a_clear_counter: assert property ( // [RL10]
    clear_watchdog_instruction || halt_instruction |=> cnt_q == 18'h00000)
    else $error("counter not cleared");
  a_cause_upper_zero: assert property ( // [RL11]
    setup && hit_cause |=> prdata[31:4] == 28'h0000000)
    else $error("cause upper bits not zero");
  a_pdf_halt_clear: assert property ( // [RL13]
    halt_instruction |=> power_down_flag ##1 (power_down_flag || $past(clear_watchdog_instruction)))
    else $error("power-down flag wrong");
  a_ovf_restart: assert property ( // [RL14]
    ovf |-> cnt_q == period_last(ctrl_q.timeout_period_select) ##1 cnt_q == 18'h00000)
    else $error("overflow count or restart wrong");
  a_stop_no_reset: assert property ( // [RL3]
    gmode == wdt_pkg::GUARD_STOP |=> !device_reset)
    else $error("disabled watchdog issued a reset");
  a_guard_clears_cnt: assert property ( // [RL10]
    guard_bad |=> cnt_q == 18'h00000)
    else $error("illegal guard left counter running");
  a_cause_sw_clear: assert property ( // [RL7]
    wr_en && hit_cause && !pwdata[0] && !guard_fire |=> !cause_q.watchdog_ctrl_reset_flag)
    else $error("cause flag not cleared by write of zero");
  a_pdf_clear_instr: assert property ( // [RL13]
    clear_watchdog_instruction && !halt_instruction |=> !power_down_flag)
    else $error("clear instruction left power-down flag set");
  a_sleep_keeps_ctrl: assert property ( // [RL9]
    ovf && sleep_idle && !(wr_en && hit_ctrl) |=> $stable(ctrl_q))
    else $error("sleep overflow changed control");
  a_tick_period: assert property ( // [RL1]
    tick |-> $past(div_q) == wdt_pkg::DIV_W'(OSC_DIV_CYC - 2))
    else $error("oscillator tick spacing wrong");
  a_run_ovf_ctrl: assert property ( // [RL8]
    ovf && !sleep_idle |=> ctrl_q == wdt_pkg::CTRL_RESET)
    else $error("run overflow kept control value");
  a_halt_keeps_count: assert property ( // [RL12]
    halt_instruction ##1 run && tick && !cnt_clear |=> cnt_q == 18'h00001)
    else $error("enabled watchdog stopped after halt");

endmodule

// ===== test/watchdog_timer_with_reset_flags_bench.sv
`timescale 1ns/1ps
module watchdog_timer_with_reset_flags_bench;
  localparam int DIV = 4;
  localparam int SRST = 20;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dev_rst, pcsp_rst, to_flag, pd_flag, irq;
  // Instruction and cause pulses: clear, halt, soft, undervoltage, undervoltage cfg
  logic [4:0] ev = 5'h00;
  logic sleep_idle = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic [31:0] rd;
  logic err;

  wdt_core #(.SRESET_CYC(SRST), .OSC_DIV_CYC(DIV)) u_wdt_core (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_watchdog_instruction(ev[4]), .halt_instruction(ev[3]), .sleep_idle(sleep_idle),
    .soft_reset_event(ev[2]), .undervoltage_event(ev[1]), .undervoltage_cfg_event(ev[0]),
    .device_reset(dev_rst), .pc_sp_reset(pcsp_rst), .timeout_flag(to_flag),
    .power_down_flag(pd_flag), .irq(irq));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 8)
    begin
      fail_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev <= 5'h01 << k;
    @(posedge ref_clk);
    ev <= 5'h00;
    @(posedge ref_clk);
  endtask

  // Counts edges until the chosen reset pulse; a lost pulse ends the run
  task automatic wait_rst(input logic pc, input int max);
    for (n = 0; n < max; n++)
    begin
      @(posedge ref_clk);
      if ((pc ? pcsp_rst : dev_rst) === 1'b1)
        return;
    end
    fail_count++;
    conclude();
  endtask

  task automatic t_reset();
    apb(1'b0, wdt_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h53);
    apb(1'b0, wdt_pkg::ADDR_CAUSE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask

  task automatic t_period();
    int c;
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, wdt_pkg::ADDR_CTRL, {24'h000000, wdt_pkg::GUARD_ENABLE, s[2:0]});
      pulse(4);
      c = (256 << (2 * s)) * DIV;
      wait_rst(1'b0, 20000);
      check({31'h0, n >= c - DIV && n <= c + 2 * DIV}, 32'h1);
      @(posedge ref_clk);
      check({31'h0, to_flag}, 32'h1);
      apb(1'b0, wdt_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h53);
    end
    apb(1'b0, wdt_pkg::ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
    apb(1'b0, wdt_pkg::ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 32'h0);
  endtask

  task automatic t_halt();
    pulse(3);
    check({31'h0, pd_flag}, 32'h1);
    check({31'h0, to_flag}, 32'h0);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, rd < 32'h2}, 32'h1);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, rd > 32'h1}, 32'h1);
    pulse(4);
    check({31'h0, pd_flag}, 32'h0);
  endtask

  task automatic t_sleep();
    sleep_idle <= 1'b1;
    apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h50);
    pulse(4);
    wait_rst(1'b1, 2000);
    check({31'h0, dev_rst}, 32'h0);
    @(posedge ref_clk);
    check({31'h0, to_flag}, 32'h1);
    apb(1'b0, wdt_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h50);
    apb(1'b0, wdt_pkg::ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h1);
    sleep_idle <= 1'b0;
  endtask

  task automatic t_disable();
    apb(1'b1, wdt_pkg::ADDR_CTRL, 32'ha8);
    pulse(4);
    repeat (1500) @(posedge ref_clk);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, wdt_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'ha8);
  endtask

  task automatic t_guard();
    apb(1'b1, wdt_pkg::ADDR_CTRL, 32'h00);
    wait_rst(1'b0, 100);
    check({31'h0, n >= SRST - 2 && n <= SRST + 4}, 32'h1);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, rd < 32'h3}, 32'h1);
    apb(1'b0, wdt_pkg::ADDR_CAUSE, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, wdt_pkg::ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, wdt_pkg::ADDR_IRQ_STAT, 32'h2);
    apb(1'b1, wdt_pkg::ADDR_CAUSE, 32'hff);
    apb(1'b0, wdt_pkg::ADDR_CAUSE, 32'h0);
    check(rd, 32'h0f);
    apb(1'b1, wdt_pkg::ADDR_CAUSE, 32'h01);
    pulse(4);
    pulse(3);
    pulse(2);
    pulse(1);
    pulse(0);
    apb(1'b0, wdt_pkg::ADDR_CAUSE, 32'h0);
    check(rd, 32'h0f);
    apb(1'b1, wdt_pkg::ADDR_CAUSE, 32'h0);
    apb(1'b0, wdt_pkg::ADDR_CAUSE, 32'h0);
    check(rd, 32'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_period();
    t_halt();
    t_sleep();
    t_disable();
    t_guard();
    conclude();
  end
endmodule
